/* hw/rs_encoder_pkg.sv */
package rs_encoder_pkg;

    // ****************************************
    // code limits and defaults
    // ****************************************
    localparam int SYM_W_DEFAULT = 8;
    localparam int SYM_W_MIN = 3;
    localparam int SYM_W_MAX = 12;
    localparam int N_DEFAULT = 255;
    localparam int K_DEFAULT = 239;
    localparam int N_MIN = 3;
    localparam int R_MIN = 2;
    localparam int R_SPAN = 256;
    localparam int GEN_START_DEFAULT = 0;
    localparam int SCALE_DEFAULT = 1;
    localparam int NUM_CH_DEFAULT = 1;
    localparam int NUM_CH_MAX = 128;
    localparam int MARK_W_DEFAULT = 1;

    typedef enum {CODE_CUSTOM, CODE_BROADCAST, CODE_TERRESTRIAL, CODE_SPACE, CODE_CABLE,
        CODE_SAT126} code_t;
    typedef enum {GEN_FIXED, GEN_AREA, GEN_FLEX} gen_style_t;

    function automatic int presetN(code_t c, int nCustom);
        case (c)
            CODE_BROADCAST: return 204;
            CODE_TERRESTRIAL: return 207;
            CODE_SPACE: return 255;
            CODE_CABLE: return 128;
            CODE_SAT126: return 126;
            default: return nCustom;
        endcase
    endfunction : presetN

    function automatic int presetK(code_t c, int kCustom);
        case (c)
            CODE_BROADCAST: return 188;
            CODE_TERRESTRIAL: return 187;
            CODE_SPACE: return 223;
            CODE_CABLE: return 122;
            CODE_SAT126: return 112;
            default: return kCustom;
        endcase
    endfunction : presetK

    function automatic int defaultPoly(int s);
        case (s)
            3: return 11;
            4: return 19;
            5: return 37;
            6: return 67;
            7: return 137;
            8: return 285;
            9: return 529;
            10: return 1033;
            11: return 2053;
            default: return 4179;
        endcase
    endfunction : defaultPoly

    // ****************************************
    // register map
    // ****************************************
    localparam logic [3:0] REG_CTRL = 4'h0;
    localparam logic [3:0] REG_STATUS = 4'h4;
    localparam logic [3:0] REG_BLKCNT = 4'h8;
    localparam logic [3:0] REG_CODE = 4'hC;
    localparam int CTRL_EN_BIT = 0;
    localparam logic CTRL_EN_RESET = 1'b1;
    localparam int CODE_R_POS = 16;
    localparam int EV_W = 3;

    typedef struct packed {
        logic ctrlInvalid;
        logic lastUnexpected;
        logic lastMissing;
    } event_t;

endpackage : rs_encoder_pkg

/* hw/rs_encoder.sv */
// Decided for this implementation: the AHB-Lite register port and the register offsets.
`timescale 1ns/100ps
// Operation
// R1: info symbols pass, then n-k parity appended
// R2: symbol width parameter 3..12, default 8
// R3: field polynomial parameter, zero picks default
// R4: generator roots alpha^(h*(start+j))
// R5: scaling factor h, coprime to 2^s-1
// R6: n from 3 to 2^s-1, shortened allowed
// R7: k from max(n-256,1) to n-2
// R8: preset codes selectable by parameter
// R9: upstream presents one symbol per handshake
// R10: input last only feeds event flags
// R11: flag missing last at block end
// R12: flag last seen before block end
// R13: output info then parity, same type
// R14: output last high on final code symbol
// R15: optional output ready gives back-pressure
// R16: per-block n on control stream
// R17: per-block r on control stream
// R18: flag illegal control n or r
// R19: parity generator style fixed, area, flexibility
// R20: caller holds reset for two clocks
// R21: clock enable input qualifies the clock
// R22: up to 128 interleaved channels
// R23: info flag on last information symbol
// R24: marker bits travel aligned with symbols
// R25: clock enable low freezes state and outputs; the code forces outTvalid, inTready and ctrlTready low, and events low from the next clock
// R26: transfer only when valid and ready high
module rs_encoder
    import rs_encoder_pkg::*;
#(
    parameter code_t CODE = CODE_CUSTOM,
    parameter int SYM_W = SYM_W_DEFAULT, // R2
    parameter int N_CFG = N_DEFAULT,
    parameter int K_CFG = K_DEFAULT,
    parameter int FIELD_POLY = 0,
    parameter int GEN_START = GEN_START_DEFAULT,
    parameter int SCALE_H = SCALE_DEFAULT,
    parameter bit VAR_N = 1'b0,
    parameter bit VAR_R = 1'b0,
    parameter gen_style_t GEN_STYLE = GEN_FLEX,
    parameter int NUM_CH = NUM_CH_DEFAULT,
    parameter bit HAS_OUT_READY = 1'b1,
    parameter bit HAS_INFO = 1'b1,
    parameter int MARK_W = MARK_W_DEFAULT
) (
    input wire logic clk,
    input wire logic reset,
    input wire logic clkEn,
    input wire logic inTvalid,
    output logic inTready,
    input wire logic [SYM_W-1:0] inTdata,
    input wire logic inTlast,
    input wire logic [MARK_W-1:0] inTuser,
    output logic outTvalid,
    input wire logic outTready,
    output logic [SYM_W-1:0] outTdata,
    output logic outTlast,
    output logic outTinfo,
    output logic [MARK_W-1:0] outTuser,
    input wire logic ctrlTvalid,
    output logic ctrlTready,
    input wire logic [SYM_W-1:0] ctrlTdataN,
    input wire logic [$clog2(presetN(CODE, N_CFG) - presetK(CODE, K_CFG) + 1)-1:0] ctrlTdataR,
    output event_t events,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic hreadyout,
    output logic hresp,
    output logic [31:0] hrdata
);

    // ****************************************
    // derived code constants
    // ****************************************
    localparam int N = presetN(CODE, N_CFG); // R8
    localparam int K = presetK(CODE, K_CFG); // R8
    localparam int R_DEF = N - K;
    localparam int RW = $clog2(R_DEF + 1); // R17
    localparam int CW = (NUM_CH > 1) ? $clog2(NUM_CH) : 1;
    localparam int POLY = (FIELD_POLY == 0) ? defaultPoly(SYM_W) : FIELD_POLY; // R3
    localparam logic [SYM_W-1:0] POLY_LO = SYM_W'(POLY); // R3
    localparam int ORDER = (1 << SYM_W) - 1;
    // area style limits control n to the configured n instead of 2^s-1
    localparam int N_CAP = (GEN_STYLE == GEN_AREA) ? N : ORDER; // R19 R6
    localparam bit USE_CTRL = VAR_N || VAR_R;

    typedef logic [R_DEF:0][SYM_W-1:0] gen_t;
    typedef logic [R_DEF-1:0][SYM_W-1:0] row_t;

    // ****************************************
    // field arithmetic
    // ****************************************
    function automatic logic [SYM_W-1:0] gfMul(input logic [SYM_W-1:0] a,
        input logic [SYM_W-1:0] b);
        logic [SYM_W-1:0] acc;
        logic [SYM_W-1:0] sh;
        acc = '0;
        sh = a;
        for (int i = 0; i < SYM_W; i++) begin
            if (b[i]) begin
                acc = acc ^ sh;
            end
            sh = sh[SYM_W-1] ? ({sh[SYM_W-2:0], 1'b0} ^ POLY_LO) : {sh[SYM_W-2:0], 1'b0};
        end
        return acc;
    endfunction : gfMul

    function automatic logic [SYM_W-1:0] gfPow(input int e);
        logic [SYM_W-1:0] x;
        x = SYM_W'(1);
        for (int i = 0; i < (e % ORDER); i++) begin
            x = gfMul(x, SYM_W'(2));
        end
        return x;
    endfunction : gfPow

    // built at elaboration; one product per supported r
    function automatic gen_t genPoly(input int r);
        gen_t g;
        logic [SYM_W-1:0] root;
        logic [SYM_W-1:0] stepA;
        g = '0;
        g[0] = SYM_W'(1);
        root = gfPow(SCALE_H * GEN_START); // R4 R5
        stepA = gfPow(SCALE_H); // R5
        for (int j = 0; j < R_DEF; j++) begin
            if (j < r) begin
                for (int i = R_DEF; i > 0; i--) begin
                    g[i] = g[i-1] ^ gfMul(root, g[i]); // R4
                end
                g[0] = gfMul(root, g[0]);
                root = gfMul(root, stepA);
            end
        end
        return g;
    endfunction : genPoly

    gen_t genRom [R_DEF+1];
    genvar gr;
    generate
        for (gr = 0; gr <= R_DEF; gr++) begin : g_rom
            assign genRom[gr] = genPoly(gr); // R4 R19
        end
    endgenerate

    // ****************************************
    // state
    // ****************************************
    logic [NUM_CH-1:0][SYM_W-1:0] pos_q, pos_d;
    logic [NUM_CH-1:0][SYM_W-1:0] nBlk_q, nBlk_d;
    logic [NUM_CH-1:0][RW-1:0] rBlk_q, rBlk_d;
    row_t par_q [NUM_CH];
    row_t par_d [NUM_CH];
    logic [CW-1:0] ch_q, ch_d;
    logic outValid_q, outValid_d;
    logic [SYM_W-1:0] outData_q, outData_d;
    logic outLast_q, outLast_d;
    logic outInfo_q, outInfo_d;
    logic [MARK_W-1:0] outUser_q, outUser_d;
    event_t ev_q, ev_d;
    logic enable_q, enable_d;
    logic [EV_W-1:0] sticky_q, sticky_d;
    logic [31:0] blkCnt_q, blkCnt_d;
    logic wrPend_q, wrPend_d;
    logic [3:0] wrAddr_q, wrAddr_d;
    logic [31:0] hrdata_q, hrdata_d;

    // ****************************************
    // stream datapath
    // ****************************************
    wire logic outReadyEff = HAS_OUT_READY ? outTready : 1'b1; // R15
    wire logic transfer = outTvalid && outReadyEff; // R26
    wire logic advance = clkEn && enable_q && (!outValid_q || transfer); // R25 R15
    wire logic [SYM_W-1:0] curPos = pos_q[ch_q];
    wire logic blockStart = (curPos == '0);
    wire logic needCtrl = USE_CTRL && blockStart;
    wire logic [SYM_W-1:0] nIn = VAR_N ? ctrlTdataN : SYM_W'(N); // R16
    wire logic [RW-1:0] rIn = VAR_R ? ctrlTdataR : RW'(R_DEF); // R17
    wire logic ctrlBad = (int'(nIn) < N_MIN) || (int'(nIn) > N_CAP) || (int'(rIn) < R_MIN)
        || (int'(rIn) > R_DEF) || (int'(rIn) > R_SPAN)
        || (int'(rIn) >= int'(nIn)); // R18 R6 R7
    // a bad control word falls back to the default code
    wire logic [SYM_W-1:0] bN = blockStart ? (ctrlBad ? SYM_W'(N) : nIn) : nBlk_q[ch_q];
    wire logic [RW-1:0] bR = blockStart ? (ctrlBad ? RW'(R_DEF) : rIn) : rBlk_q[ch_q];
    wire logic [SYM_W-1:0] kBlk = bN - SYM_W'(bR); // R16
    wire logic infoPhase = (curPos < kBlk);
    wire logic isLastInfo = (curPos == kBlk - SYM_W'(1));
    wire logic isLastCode = (curPos == bN - SYM_W'(1));
    wire logic ctrlOk = !needCtrl || ctrlTvalid;
    wire logic inTake = inTvalid && inTready; // R9 R26
    wire logic parTake = advance && !infoPhase;
    wire logic step = inTake || parTake;
    wire gen_t coef = genRom[bR];
    wire row_t rowIn = blockStart ? '0 : par_q[ch_q];
    wire logic [SYM_W-1:0] parTop = rowIn[bR - RW'(1)];
    wire logic [SYM_W-1:0] fb = inTdata ^ parTop;

    assign inTready = advance && infoPhase && ctrlOk;
    assign ctrlTready = advance && needCtrl && inTvalid; // R16 R17

    row_t newRow;
    always_comb begin
        newRow = rowIn;
        if (inTake) begin
            newRow[0] = gfMul(fb, coef[0]); // R1
            for (int i = 1; i < R_DEF; i++) begin
                newRow[i] = rowIn[i-1] ^ gfMul(fb, coef[i]); // R1
            end
        end else if (parTake) begin
            newRow[0] = '0;
            for (int i = 1; i < R_DEF; i++) begin
                newRow[i] = rowIn[i-1];
            end
        end
    end

    always_comb begin
        pos_d = pos_q;
        nBlk_d = nBlk_q;
        rBlk_d = rBlk_q;
        par_d = par_q;
        ch_d = ch_q;
        if (step) begin
            pos_d[ch_q] = isLastCode ? '0 : curPos + SYM_W'(1); // R6
            nBlk_d[ch_q] = bN; // R16
            rBlk_d[ch_q] = bR; // R17
            par_d[ch_q] = newRow;
            ch_d = (ch_q == CW'(NUM_CH - 1)) ? '0 : ch_q + CW'(1); // R22
        end
    end

    always_comb begin
        outValid_d = outValid_q;
        outData_d = outData_q;
        outLast_d = outLast_q;
        outInfo_d = outInfo_q;
        outUser_d = outUser_q;
        if (step) begin
            outValid_d = 1'b1;
            outData_d = inTake ? inTdata : parTop; // R1 R13
            outLast_d = isLastCode; // R14
            outInfo_d = HAS_INFO && isLastInfo && inTake; // R23
            outUser_d = inTake ? inTuser : '0; // R24
        end else if (transfer) begin
            outValid_d = 1'b0;
        end
    end

    // ****************************************
    // events
    // ****************************************
    always_comb begin
        ev_d = '0;
        if (clkEn) begin
            ev_d.lastMissing = inTake && isLastInfo && !inTlast; // R11 R10
            ev_d.lastUnexpected = inTake && inTlast && !isLastInfo; // R12 R10
            ev_d.ctrlInvalid = USE_CTRL && ctrlTready && ctrlTvalid && ctrlBad; // R18
        end
    end

    // ****************************************
    // register slave
    // ****************************************
    wire logic addrTake = hsel && hready && htrans[1];
    wire logic wrHit = wrPend_q && (wrAddr_q == REG_CTRL);
    wire logic clrHit = wrPend_q && (wrAddr_q == REG_STATUS);
    wire logic addrOk = (haddr[31:4] == '0) && (haddr[1:0] == 2'b00);
    wire logic [31:0] codeWord = (32'(rBlk_q[0]) << CODE_R_POS) | 32'(nBlk_q[0]);
    logic [31:0] rdMux;
    always_comb begin
        case (haddr[3:0])
            REG_CTRL: rdMux = 32'(enable_q);
            REG_STATUS: rdMux = 32'(sticky_q);
            REG_BLKCNT: rdMux = blkCnt_q;
            REG_CODE: rdMux = codeWord;
            default: rdMux = 32'h0000_0000;
        endcase
    end

    assign wrPend_d = addrTake && hwrite && addrOk;
    assign wrAddr_d = addrTake ? haddr[3:0] : wrAddr_q;
    assign hrdata_d = (addrTake && !hwrite) ? (addrOk ? rdMux : 32'h0000_0000) : hrdata_q;
    assign enable_d = wrHit ? hwdata[CTRL_EN_BIT] : enable_q;
    // a new event beats a simultaneous clear
    assign sticky_d = (sticky_q & ~(clrHit ? hwdata[EV_W-1:0] : '0)) | ev_q;
    assign blkCnt_d = (step && isLastCode) ? blkCnt_q + 32'h0000_0001 : blkCnt_q;

    // ****************************************
    // flip-flops
    // ****************************************
    always_ff @(posedge clk) begin
        if (reset) begin
            pos_q <= '0;
            nBlk_q <= '0;
            rBlk_q <= '0;
            par_q <= '{default: '0};
            ch_q <= '0;
        end else begin
            pos_q <= pos_d;
            nBlk_q <= nBlk_d;
            rBlk_q <= rBlk_d;
            par_q <= par_d;
            ch_q <= ch_d;
        end
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            outValid_q <= 1'b0;
            outData_q <= '0;
            outLast_q <= 1'b0;
            outInfo_q <= 1'b0;
            outUser_q <= '0;
            ev_q <= '0;
        end else begin
            outValid_q <= outValid_d;
            outData_q <= outData_d;
            outLast_q <= outLast_d;
            outInfo_q <= outInfo_d;
            outUser_q <= outUser_d;
            ev_q <= ev_d;
        end
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            enable_q <= CTRL_EN_RESET;
            sticky_q <= '0;
            blkCnt_q <= '0;
            wrPend_q <= 1'b0;
            wrAddr_q <= '0;
            hrdata_q <= '0;
        end else begin
            enable_q <= enable_d;
            sticky_q <= sticky_d;
            blkCnt_q <= blkCnt_d;
            wrPend_q <= wrPend_d;
            wrAddr_q <= wrAddr_d;
            hrdata_q <= hrdata_d;
        end
    end

    // ****************************************
    // outputs
    // ****************************************
    // valid is masked while the clock enable is low, so no beat leaves
    assign outTvalid = outValid_q && clkEn; // R25 R21
    assign outTdata = outData_q;
    assign outTlast = outLast_q;
    assign outTinfo = outInfo_q;
    assign outTuser = outUser_q;
    assign events = ev_q;
    assign hreadyout = 1'b1;
    assign hresp = 1'b0;
    assign hrdata = hrdata_q;

endmodule : rs_encoder

/* verif/rs_encoder_asserts.sv */
`timescale 1ns/100ps
module rs_encoder_asserts
    import rs_encoder_pkg::*;
#(
    parameter int SYM_W = 8,
    parameter int N_CFG = 6,
    parameter int K_CFG = 4
) (
    input wire logic clk,
    input wire logic reset,
    input wire logic clkEn,
    input wire logic inTvalid,
    input wire logic inTready,
    input wire logic inTlast,
    input wire logic outTvalid,
    input wire logic outTready,
    input wire logic [SYM_W-1:0] outTdata,
    input wire logic outTlast,
    input wire logic outTinfo,
    input wire event_t events
);
    // ****************************************
    // beat counters and properties
    // ****************************************
    logic [15:0] inCnt_q;
    logic [15:0] outCnt_q;
    wire inTake = inTvalid && inTready;
    wire outTake = outTvalid && outTready;
    wire endInfo = inTake && (inCnt_q == 16'(K_CFG - 1));
    always_ff @(posedge clk) begin
        if (reset) begin
            inCnt_q <= '0;
            outCnt_q <= '0;
        end else begin
            if (inTake) inCnt_q <= endInfo ? '0 : inCnt_q + 16'h1;
            if (outTake) outCnt_q <= (outCnt_q == 16'(N_CFG - 1)) ? '0 : outCnt_q + 16'h1;
        end
    end
    default clocking cb @(posedge clk); endclocking
    default disable iff (reset);
    sequence takeEnd;
        endInfo;
    endsequence
    // gap length fixed to n-k of the bench build
    sequence parityGap;
        !inTready [*2];
    endsequence
    parity_gap_a: assert property (takeEnd |=> parityGap)
        else $error("input accepted during parity beats");
    out_after_a: assert property (inTake |=> outTvalid || !clkEn)
        else $error("no output beat after accepted input");
    out_hold_a: assert property (outTvalid && !outTready |=>
        !clkEn || (outTvalid && $stable(outTdata)))
        else $error("stalled output beat changed");
    freeze_out_a: assert property (!clkEn |-> !outTvalid && !inTready)
        else $error("activity while clock enable low");
    last_pos_a: assert property (outTvalid |-> outTlast == (outCnt_q == 16'(N_CFG - 1)))
        else $error("output last misplaced");
    info_pos_a: assert property (outTvalid |-> outTinfo == (outCnt_q == 16'(K_CFG - 1)))
        else $error("info flag misplaced");
    miss_last_a: assert property (takeEnd and !inTlast |=> events.lastMissing)
        else $error("missing last not flagged");
    early_last_a: assert property (inTake && !endInfo && inTlast |=> events.lastUnexpected)
        else $error("unexpected last not flagged");
    quiet_ev_a: assert property (inTake && endInfo == inTlast |=>
        !events.lastMissing && !events.lastUnexpected)
        else $error("spurious framing event");
endmodule : rs_encoder_asserts

bind rs_encoder rs_encoder_asserts #(.SYM_W(SYM_W), .N_CFG(N_CFG), .K_CFG(K_CFG)) u_chk (
    .clk(clk), .reset(reset), .clkEn(clkEn), .inTvalid(inTvalid), .inTready(inTready),
    .inTlast(inTlast), .outTvalid(outTvalid), .outTready(outTready), .outTdata(outTdata),
    .outTlast(outTlast), .outTinfo(outTinfo), .events(events));

/* verif/rs_sink.sv */
`timescale 1ns/100ps
module rs_sink (
    input wire logic clk,
    input wire logic reset,
    input wire logic slow,
    input wire logic outTvalid,
    output logic outTready,
    input wire logic [7:0] outTdata,
    input wire logic outTuser,
    input wire logic outTlast
);
    // ****************************************
    // downstream sink
    // ****************************************
    logic [9:0] got[$];
    logic [1:0] phase_q;
    always @(posedge clk) begin
        if (reset) begin
            outTready <= 1'b0;
            phase_q <= 2'h0;
        end else begin
            phase_q <= phase_q + 2'h1;
            outTready <= !slow || (phase_q != 2'h0);
            if (outTvalid && outTready) got.push_back({outTlast, outTuser, outTdata});
        end
    end
endmodule : rs_sink

/* verif/tb.sv */
`timescale 1ns/100ps
module tb
    import rs_encoder_pkg::*;
;
    // ****************************************
    // bench
    // ****************************************
    localparam int N = 6;
    localparam int K = 4;
    logic clk, reset, clkEn, inTvalid, inTlast, inTuser, slow, hsel, hwrite, ctrlTvalid;
    logic [7:0] inTdata, ctrlN;
    logic [31:0] haddr, hwdata;
    logic [1:0] htrans;
    logic [2:0] hsize;
    wire inTready, outTvalid, outTready, outTlast, outTuser, hreadyout, ctrlTready;
    wire [7:0] outTdata;
    wire [31:0] hrdata;
    int errTotal, numChecks;
    logic [9:0] exp[$];
    rs_encoder #(.N_CFG(N), .K_CFG(K), .VAR_N(1'b1), .VAR_R(1'b1)) u_dut (.clk(clk),
        .reset(reset), .clkEn(clkEn),
        .inTvalid(inTvalid), .inTready(inTready), .inTdata(inTdata), .inTlast(inTlast),
        .inTuser(inTuser), .outTvalid(outTvalid), .outTready(outTready), .outTdata(outTdata),
        .outTlast(outTlast), .outTinfo(), .outTuser(outTuser), .ctrlTvalid(ctrlTvalid),
        .ctrlTready(ctrlTready), .ctrlTdataN(ctrlN), .ctrlTdataR(2'(N - K)), .events(),
        .hsel(hsel),
        .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
        .hready(hreadyout), .hreadyout(hreadyout), .hresp(), .hrdata(hrdata));
    rs_sink u_sink (.clk(clk), .reset(reset), .slow(slow), .outTvalid(outTvalid),
        .outTready(outTready), .outTdata(outTdata), .outTuser(outTuser), .outTlast(outTlast));
    initial begin
        clk = 1'b0;
        forever #10 clk = ~clk;
    end
    function automatic logic [7:0] gfMul(input logic [7:0] a, input logic [7:0] b);
        logic [7:0] r;
        r = 8'h00;
        for (int i = 0; i < 8; i++) begin
            if (b[i]) r = r ^ a;
            a = {a[6:0], 1'b0} ^ (a[7] ? 8'h1D : 8'h00);
        end
        return r;
    endfunction : gfMul
    task automatic testDone;
        $display("checks %0d errors %0d", numChecks, errTotal);
        if (errTotal == 0 && numChecks > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask : testDone
    task automatic tmo(input bit bad);
        if (bad) begin
            errTotal++;
            testDone();
        end
    endtask : tmo
    task automatic chk(input logic [31:0] g, input logic [31:0] e);
        numChecks++;
        if (g !== e) begin
            errTotal++;
            $display("mismatch at %0t: got %h expected %h", $time, g, e);
        end
    endtask : chk
    task automatic ahb(input logic wr, input logic [31:0] a, input logic [31:0] wd,
        output logic [31:0] rd);
        int n;
        hsel <= 1'b1;
        htrans <= 2'h2;
        haddr <= a;
        hwrite <= wr;
        hsize <= 3'h2;
        n = 0;
        do begin
            @(posedge clk);
            n++;
        end while (hreadyout !== 1'b1 && n < 200);
        tmo(hreadyout !== 1'b1);
        htrans <= 2'h0;
        hwdata <= wd;
        n = 0;
        do begin
            @(posedge clk);
            n++;
        end while (hreadyout !== 1'b1 && n < 200);
        tmo(hreadyout !== 1'b1);
        rd = hrdata;
    endtask : ahb
    task automatic rdChk(input logic [3:0] a, input logic [31:0] e);
        logic [31:0] r;
        ahb(1'b0, 32'(a), 32'h0, r);
        chk(r, e);
    endtask : rdChk
    task automatic wr(input logic [3:0] a, input logic [31:0] d);
        logic [31:0] r;
        ahb(1'b1, 32'(a), d, r);
    endtask : wr
    task automatic putSym(input logic [7:0] d, input logic l, input logic u);
        int n;
        inTvalid <= 1'b1;
        inTdata <= d;
        inTlast <= l;
        inTuser <= u;
        n = 0;
        do begin
            @(posedge clk);
            n++;
        end while (inTready !== 1'b1 && n < 200);
        tmo(inTready !== 1'b1);
    endtask : putSym
    task automatic sendBlock(input logic [7:0] base, input int lastAt, input bit frz);
        logic [7:0] p0, p1, fb, d;
        p0 = 8'h00;
        p1 = 8'h00;
        for (int i = 0; i < K; i++) begin
            d = base + 8'(i * 37);
            fb = d ^ p1;
            p1 = p0 ^ gfMul(fb, 8'h03);
            p0 = gfMul(fb, 8'h02);
            exp.push_back({1'b0, d[0], d});
            if (frz && i == 2) begin
                // valid drops so no stale symbol is offered during the freeze
                inTvalid <= 1'b0;
                clkEn <= 1'b0;
                repeat (3) begin
                    @(posedge clk);
                    chk(32'(outTvalid), 32'h0);
                end
                clkEn <= 1'b1;
            end
            if (i == 0) begin
                ctrlTvalid <= 1'b1;
            end
            putSym(d, 1'(i == lastAt), d[0]);
            if (i == 0) begin
                ctrlTvalid <= 1'b0;
                chk(32'(ctrlTready), 32'h1);
            end
        end
        inTvalid <= 1'b0;
        exp.push_back({2'b00, p1});
        exp.push_back({2'b10, p0});
    endtask : sendBlock
    task automatic drain;
        int n;
        n = 0;
        while (u_sink.got.size() < exp.size() && n < 400) begin
            @(posedge clk);
            n++;
        end
        tmo(u_sink.got.size() < exp.size());
        while (exp.size() > 0) begin
            chk(32'(u_sink.got.pop_front()), 32'(exp.pop_front()));
        end
    endtask : drain
    task automatic regScen;
        rdChk(REG_CTRL, 32'h1);
        rdChk(REG_STATUS, 32'h0);
        rdChk(REG_BLKCNT, 32'h0);
        rdChk(REG_CODE, 32'h0);
        rdChk(4'h2, 32'h0);
        wr(REG_CTRL, 32'h0);
        rdChk(REG_CTRL, 32'h0);
        chk(32'(inTready), 32'h0);
        wr(REG_CTRL, 32'h1);
    endtask : regScen
    task automatic blockScen;
        slow <= 1'b1;
        sendBlock(8'h11, K - 1, 1'b0);
        @(posedge clk);
        sendBlock(8'hA0, K - 1, 1'b0);
        drain();
        slow <= 1'b0;
        rdChk(REG_BLKCNT, 32'h2);
        rdChk(REG_CODE, 32'h0002_0006);
    endtask : blockScen
    task automatic eventScen;
        ctrlN <= 8'h02;
        sendBlock(8'h5C, 1, 1'b0);
        drain();
        ctrlN <= 8'(N);
        rdChk(REG_STATUS, 32'h7);
        rdChk(REG_CODE, 32'h0002_0006);
        wr(REG_STATUS, 32'h7);
        rdChk(REG_STATUS, 32'h0);
    endtask : eventScen
    task automatic freezeScen;
        sendBlock(8'h3E, K - 1, 1'b1);
        drain();
        rdChk(REG_BLKCNT, 32'h4);
    endtask : freezeScen
    initial begin
        reset = 1'b1;
        clkEn = 1'b1;
        {inTvalid, inTlast, inTuser, slow, hsel, hwrite, ctrlTvalid} = 7'h00;
        inTdata = 8'h00;
        ctrlN = 8'(N);
        {haddr, hwdata} = 64'h0;
        htrans = 2'h0;
        hsize = 3'h0;
        errTotal = 0;
        numChecks = 0;
        repeat (20) @(posedge clk);
        reset <= 1'b0;
        regScen();
        blockScen();
        eventScen();
        freezeScen();
        testDone();
    end
endmodule : tb
